// [hdl/focr_defs.vh]
// constants for the fast overcurrent reaction block
`ifndef FOCR_DEFS_VH
`define FOCR_DEFS_VH
`define FOCR_CMD_TIMING      8'hC8
`define FOCR_CMD_REACTION    8'hCA
`define FOCR_CMD_THRESHOLD   8'hD1
`define FOCR_TIMING_RST      8'h00
`define FOCR_REACTION_RST    8'h00
`define FOCR_THRESHOLD_RST   16'hFFFF
`define FOCR_RESP_MSB        7
`define FOCR_RESP_LSB        6
`define FOCR_RETRY_MSB       5
`define FOCR_RETRY_LSB       3
`define FOCR_DELAY_MSB       2
`define FOCR_DELAY_LSB       0
`define FOCR_IOUT_UNIT_MSB   3
`define FOCR_IOUT_UNIT_LSB   2
`define FOCR_RESP_LIMIT      2'h0
`define FOCR_RETRY_NONE      3'h0
`define FOCR_RETRY_FOREVER   3'h7
`define FOCR_UNIT_1MS        16'h0001
`define FOCR_UNIT_4MS        16'h0004
`define FOCR_UNIT_16MS       16'h0010
`define FOCR_UNIT_256MS      16'h0100
`define FOCR_CLK_HZ          20000000
`define FOCR_MS_PER_S        1000
`define FOCR_CYC_PER_MS      (`FOCR_CLK_HZ / `FOCR_MS_PER_S)
`endif

// [hdl/focr_fast_oc_reaction.v]
// fast overcurrent fault reaction: limiting phase, retries and shutdown latch
`include "focr_defs.vh"

module focr_fast_oc_reaction #(
	parameter CYC_PER_MS = `FOCR_CYC_PER_MS
) (
	input  wire        sys_clk_in,
	input  wire        nrst_in,
	input  wire        wr_en_in,
	input  wire [7:0]  wr_cmd_in,
	input  wire [15:0] wr_data_in,
	input  wire [7:0]  rd_cmd_in,
	input  wire [15:0] iout_amps_in,
	input  wire        fault_clear_in,
	output reg  [15:0] rd_data_out,
	output reg         output_enable_out,
	output reg         current_limit_out,
	output reg         oc_fast_fault_out,
	output reg         host_alert_out,
	output reg         latched_off_out
);
	localparam [3:0] ST_RUN   = 4'h1;
	localparam [3:0] ST_LIMIT = 4'h2;
	localparam [3:0] ST_WAIT  = 4'h4;
	localparam [3:0] ST_LATCH = 4'h8;

	wire [7:0]  timing_reg;
	wire [7:0]  reaction_reg;
	wire [15:0] threshold_reg;

	reg [3:0]  state_reg;
	reg [3:0]  state_next;
	reg [2:0]  attempts_reg;
	reg [2:0]  attempts_next;
	reg [31:0] div_reg;
	reg [15:0] ms_reg;
	reg [15:0] unit_ms;
	reg        restart_timer;

	wire [1:0]  resp_code  = reaction_reg[`FOCR_RESP_MSB:`FOCR_RESP_LSB];
	wire [2:0]  retry_set  = reaction_reg[`FOCR_RETRY_MSB:`FOCR_RETRY_LSB];
	wire [2:0]  delay_code = reaction_reg[`FOCR_DELAY_MSB:`FOCR_DELAY_LSB];
	wire        over_limit = (iout_amps_in > threshold_reg);
	wire [15:0] target_ms  = unit_ms << delay_code;
	wire        ms_tick    = (div_reg == CYC_PER_MS - 1);
	wire        timer_done = ms_tick && (ms_reg == target_ms - 16'h0001);
	wire        fault_evt  = (state_reg == ST_RUN) && over_limit;

	// host-writable configuration registers, 8-bit ones take the low byte
	focr_cfg_reg #(
		.WIDTH (8),
		.CMD   (`FOCR_CMD_TIMING),
		.RST   (`FOCR_TIMING_RST)
	) i_timing_cfg (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.wr_en_in   (wr_en_in),
		.wr_cmd_in  (wr_cmd_in),
		.wr_data_in (wr_data_in[7:0]),
		.value_out  (timing_reg)
	);

	focr_cfg_reg #(
		.WIDTH (8),
		.CMD   (`FOCR_CMD_REACTION),
		.RST   (`FOCR_REACTION_RST)
	) i_reaction_cfg (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.wr_en_in   (wr_en_in),
		.wr_cmd_in  (wr_cmd_in),
		.wr_data_in (wr_data_in[7:0]),
		.value_out  (reaction_reg)
	);

	focr_cfg_reg #(
		.WIDTH (16),
		.CMD   (`FOCR_CMD_THRESHOLD),
		.RST   (`FOCR_THRESHOLD_RST)
	) i_threshold_cfg (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.wr_en_in   (wr_en_in),
		.wr_cmd_in  (wr_cmd_in),
		.wr_data_in (wr_data_in),
		.value_out  (threshold_reg)
	);

	// unit length from the fault timing register
	always @* begin
		case (timing_reg[`FOCR_IOUT_UNIT_MSB:`FOCR_IOUT_UNIT_LSB])
			2'h0:    unit_ms = `FOCR_UNIT_1MS;
			2'h1:    unit_ms = `FOCR_UNIT_4MS;
			2'h2:    unit_ms = `FOCR_UNIT_16MS;
			default: unit_ms = `FOCR_UNIT_256MS;
		endcase
	end

	always @* begin
		state_next    = state_reg;
		attempts_next = attempts_reg;
		restart_timer = 1'b0;
		case (state_reg)
			ST_RUN: begin
				if (over_limit) begin
					restart_timer = 1'b1;
					if (resp_code == `FOCR_RESP_LIMIT) begin
						state_next = ST_LIMIT;
					end else if (retry_set == `FOCR_RETRY_NONE) begin
						state_next = ST_LATCH;
					end else if (retry_set == `FOCR_RETRY_FOREVER || attempts_reg < retry_set) begin
						state_next = ST_WAIT;
					end else begin
						state_next = ST_LATCH;
					end
				end
			end
			ST_LIMIT: begin
				if (timer_done) begin
					restart_timer = 1'b1;
					if (!over_limit) begin
						state_next = ST_RUN;
					end else if (retry_set == `FOCR_RETRY_NONE) begin
						state_next = ST_LATCH;
					end else if (retry_set == `FOCR_RETRY_FOREVER) begin
						state_next = ST_WAIT;
					end else if (attempts_reg < retry_set) begin
						state_next = ST_WAIT;
					end else begin
						state_next = ST_LATCH;
					end
				end
			end
			ST_WAIT: begin
				if (timer_done) begin
					state_next = ST_RUN;
					if (retry_set != `FOCR_RETRY_FOREVER) begin
						attempts_next = attempts_reg + 3'h1;
					end
				end
			end
			ST_LATCH: begin
				state_next = ST_LATCH;
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
		if (fault_clear_in) begin
			attempts_next = 3'h0;
			if (state_reg == ST_LATCH || state_reg == ST_WAIT) begin
				state_next = ST_RUN;
			end
		end
	end

	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			state_reg         <= ST_RUN;
			attempts_reg      <= 3'h0;
			div_reg           <= 32'h0;
			ms_reg            <= 16'h0;
			rd_data_out       <= 16'h0;
			output_enable_out <= 1'b1;
			current_limit_out <= 1'b0;
			oc_fast_fault_out <= 1'b0;
			host_alert_out    <= 1'b0;
			latched_off_out   <= 1'b0;
		end else begin
			case (rd_cmd_in)
				`FOCR_CMD_TIMING:    rd_data_out <= {8'h00, timing_reg};
				`FOCR_CMD_REACTION:  rd_data_out <= {8'h00, reaction_reg};
				`FOCR_CMD_THRESHOLD: rd_data_out <= threshold_reg;
				default:             rd_data_out <= 16'h0000;
			endcase
			state_reg    <= state_next;
			attempts_reg <= attempts_next;
			// millisecond timer, restarted on every phase entry
			if (restart_timer || !(state_reg == ST_LIMIT || state_reg == ST_WAIT)) begin
				div_reg <= 32'h0;
				ms_reg  <= 16'h0;
			end else if (ms_tick) begin
				div_reg <= 32'h0;
				ms_reg  <= ms_reg + 16'h0001;
			end else begin
				div_reg <= div_reg + 32'h1;
			end
			// set wins over clear
			if (fault_evt) begin
				oc_fast_fault_out <= 1'b1;
				host_alert_out    <= 1'b1;
			end else if (fault_clear_in) begin
				oc_fast_fault_out <= 1'b0;
				host_alert_out    <= 1'b0;
			end
			output_enable_out <= (state_next == ST_RUN) || (state_next == ST_LIMIT);
			current_limit_out <= (state_next == ST_LIMIT);
			latched_off_out   <= (state_next == ST_LATCH);
		end
	end
endmodule // focr_fast_oc_reaction

// one write-decoded configuration register, reset to its own value
module focr_cfg_reg #(
	parameter             WIDTH = 8,
	parameter [7:0]       CMD   = 8'h00,
	parameter [WIDTH-1:0] RST   = {WIDTH{1'h0}}
) (
	input  wire             sys_clk_in,
	input  wire             nrst_in,
	input  wire             wr_en_in,
	input  wire [7:0]       wr_cmd_in,
	input  wire [WIDTH-1:0] wr_data_in,
	output reg  [WIDTH-1:0] value_out
);
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			value_out <= RST;
		end else if (wr_en_in && (wr_cmd_in == CMD)) begin
			value_out <= wr_data_in;
		end
	end
endmodule // focr_cfg_reg

// [sim/fast_overcurrent_fault_response_tb.sv]
// self-checking bench for the fast overcurrent reaction block
module fast_overcurrent_fault_response_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  rc = 8'h00;
	logic [15:0] io = 16'h0000;
	logic        we, clr, oe, cl, f, a, lo;
	logic [7:0]  wc;
	logic [15:0] wd, rd;
	int          errors = 0;
	int          checked = 0;
	always #25 clk = ~clk;
	focr_fast_oc_reaction #(.CYC_PER_MS(4)) i_dut (.sys_clk_in(clk), .nrst_in(nrst), .wr_en_in(we),
		.wr_cmd_in(wc), .wr_data_in(wd), .rd_cmd_in(rc), .iout_amps_in(io), .fault_clear_in(clr),
		.rd_data_out(rd), .output_enable_out(oe), .current_limit_out(cl), .oc_fast_fault_out(f),
		.host_alert_out(a), .latched_off_out(lo));
	focr_host i_host (.sys_clk_in(clk), .wr_en_out(we), .wr_cmd_out(wc), .wr_data_out(wd), .fault_clear_out(clr));
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task chkb(input string n, input logic e, input logic s);
		chk(n, {15'h0, e}, {15'h0, s});
	endtask
	task rdc(input logic [7:0] c, input logic [15:0] e);
		rc = c;
		repeat (2) @(posedge clk);
		#1 chk("rd_data", e, rd);
	endtask
	task t_reg;
		rdc(8'hD1, 16'hFFFF);
		rdc(8'hC8, 16'h0000);
		rdc(8'hCA, 16'h0000);
		i_host.wr(8'hD1, 16'h0064);
		i_host.wr(8'hCA, 16'h00AB);
		rdc(8'hCA, 16'h00AB);
		rdc(8'h00, 16'h0000);
		io = 16'h0064;
		repeat (3) @(posedge clk);
		#1 chkb("flag", 1'b0, f);
		$display("t_reg done");
	endtask
	// counts samples in limiting (lim) or with the output off
	task cnt(input bit lim, input int d);
		int n;
		n = 0;
		if (lim && !cl) begin
			@(posedge clk);
			#1;
		end
		while ((lim ? cl : !oe) && n < 2000) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk(lim ? "limit" : "off", 16'(d), 16'(n));
	endtask
	task run(input logic [7:0] cfg, input logic [7:0] tim, input int d, input int k, input logic l);
		int i;
		i_host.wr(8'hC8, {8'h00, tim});
		i_host.wr(8'hCA, {8'h00, cfg});
		io = 16'h0065;
		@(posedge clk);
		#1 chkb("alert", 1'b1, a);
		for (i = 0; i < k; i++) begin
			cnt(1'b1, d);
			if (i < k - 1) cnt(1'b0, d);
		end
		chkb("latched", l, lo);
		io = 16'h0000;
		repeat (d + 4) @(posedge clk);
		i_host.clr();
		chkb("output", 1'b1, oe);
		chkb("flag", 1'b0, f);
		$display("run %h done", cfg);
	endtask
	task test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		t_reg;
		run(8'h00, 8'h00, 4, 1, 1'b1);
		run(8'h0B, 8'h04, 128, 2, 1'b1);
		run(8'h38, 8'h08, 64, 3, 1'b0);
		run(8'h40, 8'h0C, 4, 0, 1'b1);
		run(8'h00, 8'h0C, 1024, 1, 1'b1);
		test_done;
	end
	initial begin
		#300000;
		errors++;
		test_done;
	end
endmodule // fast_overcurrent_fault_response_tb

// [sim/focr_chk_sva.sv]
// port assertions for the fast overcurrent reaction block
`include "focr_defs.vh"
module focr_chk (
	input logic        sys_clk_in,
	input logic        nrst_in,
	input logic        wr_en_in,
	input logic [7:0]  wr_cmd_in,
	input logic [15:0] wr_data_in,
	input logic [7:0]  rd_cmd_in,
	input logic [15:0] iout_amps_in,
	input logic        fault_clear_in,
	input logic [15:0] rd_data_out,
	input logic        output_enable_out,
	input logic        current_limit_out,
	input logic        oc_fast_fault_out,
	input logic        host_alert_out,
	input logic        latched_off_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] thr_shadow_reg;
	logic        run_over;
	// shadow of the fault threshold, kept from the write strobes
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			thr_shadow_reg <= `FOCR_THRESHOLD_RST;
		end else if (wr_en_in && wr_cmd_in == `FOCR_CMD_THRESHOLD) begin
			thr_shadow_reg <= wr_data_in;
		end
	end
	// running (output on, not limiting) with the current above the threshold
	assign run_over = output_enable_out && !current_limit_out && (iout_amps_in > thr_shadow_reg);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	property p_flagset; run_over |=> oc_fast_fault_out && host_alert_out; endproperty
	a_flagset: assert property (p_flagset) else $error("fault not flagged");
	property p_flagsrc; $rose(oc_fast_fault_out) |-> $past(run_over); endproperty
	a_flagsrc: assert property (p_flagsrc) else $error("flag without fault");
	property p_lathold; latched_off_out && !fault_clear_in |=> latched_off_out; endproperty
	a_lathold: assert property (p_lathold) else $error("latch released");
	sequence s_wr; wr_en_in && wr_cmd_in == `FOCR_CMD_REACTION && rd_cmd_in == `FOCR_CMD_REACTION; endsequence
	sequence s_rd; !wr_en_in && rd_cmd_in == `FOCR_CMD_REACTION; endsequence
	property p_rdbk; s_wr ##1 s_rd |=> rd_data_out == ($past(wr_data_in, 2) & 16'h00FF); endproperty
	a_rdbk: assert property (p_rdbk) else $error("reaction readback");
	property p_alert; oc_fast_fault_out == host_alert_out; endproperty
	a_alert: assert property (p_alert) else $error("alert differs");
	property p_limflag; $rose(current_limit_out) |-> oc_fast_fault_out; endproperty
	a_limflag: assert property (p_limflag) else $error("limit no flag");
	property p_limon; current_limit_out |-> output_enable_out; endproperty
	a_limon: assert property (p_limon) else $error("limit output off");
	property p_latoff; latched_off_out |-> !output_enable_out; endproperty
	a_latoff: assert property (p_latoff) else $error("latched output on");
	property p_clr; fault_clear_in && latched_off_out |=> !latched_off_out; endproperty
	a_clr: assert property (p_clr) else $error("clear ignored");
	property p_unlat; $fell(latched_off_out) |-> $past(fault_clear_in); endproperty
	a_unlat: assert property (p_unlat) else $error("unlatch no clear");
	property p_restart; $rose(output_enable_out) |-> !latched_off_out && !current_limit_out; endproperty
	a_restart: assert property (p_restart) else $error("bad restart");
endmodule // focr_chk
bind focr_fast_oc_reaction focr_chk i_chk (.sys_clk_in, .nrst_in, .wr_en_in, .wr_cmd_in, .wr_data_in,
	.rd_cmd_in, .iout_amps_in, .fault_clear_in, .rd_data_out, .output_enable_out, .current_limit_out,
	.oc_fast_fault_out,
	.host_alert_out, .latched_off_out);

// [sim/focr_host.sv]
// host model: register writes and fault clear
module focr_host (
	input  logic        sys_clk_in,
	output logic        wr_en_out,
	output logic [7:0]  wr_cmd_out,
	output logic [15:0] wr_data_out,
	output logic        fault_clear_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{wr_en_out, wr_cmd_out, wr_data_out, fault_clear_out} = 26'h0;
	end
	task wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge sys_clk_in);
		#1 {wr_en_out, wr_cmd_out, wr_data_out} = {1'b1, c, d};
		@(posedge sys_clk_in);
		// released bus shows the inverse, not the last value
		#1 {wr_en_out, wr_cmd_out, wr_data_out} = {1'b0, ~c, ~d};
	endtask
	task clr;
		@(posedge sys_clk_in);
		#1 fault_clear_out = 1'b1;
		@(posedge sys_clk_in);
		#1 fault_clear_out = 1'b0;
	endtask
endmodule // focr_host
